//--- pkg/recloser_defs.vh
`ifndef RECLOSER_DEFS_VH
`define RECLOSER_DEFS_VH

// =============================================================
// time base
`define TICK_PERIOD_MS 10
`define SYS_CLK_HZ 50000000
`define TICK_CYCLES ((`SYS_CLK_HZ / 1000) * `TICK_PERIOD_MS)

// =============================================================
// register offsets
`define REG_CTRL 8'h00
`define REG_CYCLES 8'h04
`define REG_START1 8'h08
`define REG_START2 8'h0C
`define REG_RECLAIM 8'h10
`define REG_DEAD1 8'h14
`define REG_DEAD2 8'h18
`define REG_DEAD3 8'h1C
`define REG_DEAD4 8'h20
`define REG_SAFETY 8'h24
`define REG_WAITMAX 8'h28
`define REG_STATUS 8'h2C
`define REG_EVENTS 8'h30

// =============================================================
// control fields
`define CTRL_IN_SERVICE 0
`define CTRL_LOCK_ON_FINAL 1
`define CTRL_ACK 2
`define CTRL_SYNC_RESET 3

// =============================================================
// event flags
`define EV_CLEARED 0
`define EV_FINAL_TRIP 1
`define EV_INHIBITED 2

// =============================================================
// reset values; the times are in 10 ms ticks
`define RST_CYCLES 3'h1
`define RST_RECLAIM 15'h03E8
`define RST_DEAD 15'h012C
`define RST_SAFETY 15'h01F4
`define RST_WAITMAX 15'h01F4
`define RST_START 17'h00000

`endif

//--- src/breaker_recloser_sequencer.v
`timescale 1ns/1ps
// Summary of operation
// - a recloser close order starts the reclaim timer
// - reclaim expiry with no fault: reinitialise and post cleared-fault event
// - starting trip during reclaim: trip and move to next active cycle
// - after manual close, reclosing held off for safety interval
// - recloser trip in cycle n starts dead timer n, breaker held open
// - dead timer expiry starts next cycle with a close order
// - ready needs control on, in service, closed, safety over, no inhibit
// - ready status is an output for the control mapping
// - first starting trip on a fault starts first-cycle dead timer
// - fault after last cycle: final trip, event, optional close lockout
// - closing onto fault or fault during safety inhibits recloser
// - open/close order, out of service, inhibit input, failure, gear fault inhibit
// - breaker opened by non-starting trip: inhibit and final-trip event
// - breaker not recharged extends dead time up to a maximum
// - still not recharged at the maximum: inhibit
// - one to four cycles; each stage starts on inst, delayed or never
// - logic equation trip may start reclosing, cycle 1 and cycles 2-4
// - reclaim and four dead times set independently in 10 ms steps
`include "recloser_defs.vh"

module breaker_recloser_sequencer #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter STAGES = 8
) (
    // clock and reset
    input wire CLK_SYS,
    input wire RSTN,
    // register port
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // protection pickups, one bit per stage
    input wire [STAGES-1:0] TRIP_INST,
    input wire [STAGES-1:0] TRIP_DELAYED,
    input wire LOGIC_EQUATION_TRIP_OUTPUT,
    input wire OTHER_PROT_TRIP,
    input wire EXTERNAL_TRIP,
    // breaker and inhibit conditions
    input wire CB_CONTROL_ON,
    input wire CB_CLOSED,
    input wire CB_CHARGED,
    input wire MANUAL_CLOSE,
    input wire MANUAL_OPEN,
    input wire INHIBIT_IN,
    input wire BREAKER_FAILURE,
    input wire SWITCHGEAR_FAULT,
    // breaker orders and status
    output reg TRIP_ORDER,
    output reg CLOSE_ORDER,
    output reg RECLOSER_READY,
    output reg CLOSE_LOCKED,
    output reg [2:0] CYCLE
);

// =============================================================
// states
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_READY = 3'h1;
localparam [2:0] S_DEAD = 3'h2;
localparam [2:0] S_EXTEND = 3'h3;
localparam [2:0] S_RECLAIM = 3'h4;
localparam [2:0] S_FINAL = 3'h5;

reg [2:0] state;
reg [31:0] div;
reg tick;
reg [14:0] timer;
reg [14:0] safety_timer;
reg safety_done;
reg in_service;
reg lock_on_final;
reg sync_reset;
reg ack;
reg [2:0] cycles_cfg;
reg [2*STAGES:0] start1;
reg [2*STAGES:0] start2;
reg [14:0] reclaim_t;
reg [14:0] dead_t [0:3];
reg [14:0] safety_t;
reg [14:0] waitmax_t;
reg [2:0] events;
reg set_cleared;
reg set_final;
reg set_inhib;
reg cb_closed_d;
reg inhibited;
wire fault_any;
wire start_c1;
wire start_cn;
wire inhibit_cond;
wire opened_now;
wire [1:0] dead_idx;

// a stage starts reclosing if its configured output is active
// start word: inst enables, then delayed enables, then the equation bit
function starts;
    input [2*STAGES:0] cfg;
    input [STAGES-1:0] inst;
    input [STAGES-1:0] dly;
    input eq;
    begin
        starts = |(cfg[STAGES-1:0] & inst) | |(cfg[2*STAGES-1:STAGES] & dly)
            | (cfg[2*STAGES] & eq);
    end
endfunction

assign start_c1 = starts(start1, TRIP_INST, TRIP_DELAYED, LOGIC_EQUATION_TRIP_OUTPUT);
assign start_cn = starts(start2, TRIP_INST, TRIP_DELAYED, LOGIC_EQUATION_TRIP_OUTPUT);
assign fault_any = |TRIP_INST | |TRIP_DELAYED | LOGIC_EQUATION_TRIP_OUTPUT;
assign inhibit_cond = MANUAL_OPEN | MANUAL_CLOSE | ~in_service | INHIBIT_IN
    | BREAKER_FAILURE | SWITCHGEAR_FAULT;
assign opened_now = cb_closed_d & ~CB_CLOSED;
// cycles 1..4 map onto dead times 0..3; a 2-bit index cannot leave the array
assign dead_idx = CYCLE[1:0] - 2'h1;

// =============================================================
// 10 ms time base
// tick is a one-cycle pulse; a sync reset restarts the period
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        div <= 32'h00000000;
        tick <= 1'b0;
    end else if (sync_reset || div == TICK_CYCLES - 1) begin
        div <= 32'h00000000;
        tick <= ~sync_reset;
    end else begin
        div <= div + 32'h00000001;
        tick <= 1'b0;
    end
end

// =============================================================
// register writes
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        in_service <= 1'b0;
        lock_on_final <= 1'b0;
        sync_reset <= 1'b0;
        ack <= 1'b0;
        cycles_cfg <= `RST_CYCLES;
        start1 <= `RST_START;
        start2 <= `RST_START;
        reclaim_t <= `RST_RECLAIM;
        dead_t[0] <= `RST_DEAD;
        dead_t[1] <= `RST_DEAD;
        dead_t[2] <= `RST_DEAD;
        dead_t[3] <= `RST_DEAD;
        safety_t <= `RST_SAFETY;
        waitmax_t <= `RST_WAITMAX;
    end else begin
        // ack and sync reset are one-cycle pulses
        ack <= 1'b0;
        sync_reset <= 1'b0;
        if (WR) begin
            case (ADDR)
                `REG_CTRL: begin
                    in_service <= WDATA[`CTRL_IN_SERVICE];
                    lock_on_final <= WDATA[`CTRL_LOCK_ON_FINAL];
                    ack <= WDATA[`CTRL_ACK];
                    sync_reset <= WDATA[`CTRL_SYNC_RESET];
                end
                // values outside one to four are clamped
                `REG_CYCLES: cycles_cfg <= (WDATA[2:0] == 3'h0) ? 3'h1 :
                    (WDATA[2:0] > 3'h4) ? 3'h4 : WDATA[2:0];
                `REG_START1: start1 <= WDATA[2*STAGES:0];
                `REG_START2: start2 <= WDATA[2*STAGES:0];
                `REG_RECLAIM: reclaim_t <= WDATA[14:0];
                `REG_DEAD1: dead_t[0] <= WDATA[14:0];
                `REG_DEAD2: dead_t[1] <= WDATA[14:0];
                `REG_DEAD3: dead_t[2] <= WDATA[14:0];
                `REG_DEAD4: dead_t[3] <= WDATA[14:0];
                `REG_SAFETY: safety_t <= WDATA[14:0];
                `REG_WAITMAX: waitmax_t <= WDATA[14:0];
                default: ;
            endcase
        end
    end
end

// =============================================================
// register reads, one cycle later
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        RDATA <= 32'h00000000;
    end else if (RD) begin
        case (ADDR)
            `REG_CTRL: RDATA <= {30'h00000000, lock_on_final, in_service};
            `REG_CYCLES: RDATA <= {29'h00000000, cycles_cfg};
            `REG_START1: RDATA <= {{(31-2*STAGES){1'b0}}, start1};
            `REG_START2: RDATA <= {{(31-2*STAGES){1'b0}}, start2};
            `REG_RECLAIM: RDATA <= {17'h00000, reclaim_t};
            `REG_DEAD1: RDATA <= {17'h00000, dead_t[0]};
            `REG_DEAD2: RDATA <= {17'h00000, dead_t[1]};
            `REG_DEAD3: RDATA <= {17'h00000, dead_t[2]};
            `REG_DEAD4: RDATA <= {17'h00000, dead_t[3]};
            `REG_SAFETY: RDATA <= {17'h00000, safety_t};
            `REG_WAITMAX: RDATA <= {17'h00000, waitmax_t};
            // bits 4:3 are spare
            `REG_STATUS: RDATA <= {21'h000000, inhibited, CLOSE_LOCKED, RECLOSER_READY,
                CYCLE, 2'h0, state};
            `REG_EVENTS: RDATA <= {29'h00000000, events};
            default: RDATA <= 32'h00000000;
        endcase
    end else begin
        RDATA <= 32'h00000000;
    end
end

// =============================================================
// sticky events: read clears, a new event in the same cycle wins
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        events <= 3'h0;
    end else begin
        events <= ((RD && ADDR == `REG_EVENTS) ? 3'h0 : events)
            | {set_inhib, set_final, set_cleared};
    end
end

// =============================================================
// safety interval after a manual close
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        safety_timer <= 15'h0000;
        safety_done <= 1'b0;
        cb_closed_d <= 1'b0;
    end else begin
        cb_closed_d <= CB_CLOSED;
        if (sync_reset) begin
            safety_timer <= 15'h0000;
            safety_done <= 1'b0;
        end else if (MANUAL_CLOSE) begin
            // a zero safety time makes the recloser ready at once
            safety_timer <= 15'h0000;
            safety_done <= (safety_t == 15'h0000);
        end else if (!safety_done && tick) begin
            safety_timer <= safety_timer + 15'h0001;
            safety_done <= (safety_timer + 15'h0001 >= safety_t);
        end
    end
end

// =============================================================
// sequencer
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        state <= S_IDLE;
        timer <= 15'h0000;
        CYCLE <= 3'h0;
        TRIP_ORDER <= 1'b0;
        CLOSE_ORDER <= 1'b0;
        RECLOSER_READY <= 1'b0;
        CLOSE_LOCKED <= 1'b0;
        inhibited <= 1'b0;
        set_cleared <= 1'b0;
        set_final <= 1'b0;
        set_inhib <= 1'b0;
    end else begin
        set_cleared <= 1'b0;
        set_final <= 1'b0;
        set_inhib <= 1'b0;
        CLOSE_ORDER <= 1'b0;
        TRIP_ORDER <= 1'b0;
        // registered, so ready trails its conditions by one cycle
        RECLOSER_READY <= CB_CONTROL_ON & in_service & CB_CLOSED & safety_done
            & ~inhibit_cond & ~inhibited & (state == S_READY);
        if (ack) begin
            CLOSE_LOCKED <= 1'b0;
        end
        // saturate so a stale timer never wraps into a false expiry
        if (tick && timer != 15'h7FFF) begin
            timer <= timer + 15'h0001;
        end
        if (sync_reset) begin
            state <= S_IDLE;
            timer <= 15'h0000;
            CYCLE <= 3'h0;
            inhibited <= 1'b0;
            CLOSE_LOCKED <= 1'b0;
            RECLOSER_READY <= 1'b0;
        // an inhibition wins over any order due in the same cycle
        end else if (inhibit_cond && state != S_IDLE) begin
            state <= S_IDLE;
            inhibited <= 1'b1;
            set_inhib <= 1'b1;
        end else begin
            case (state)
                S_IDLE: begin
                    CYCLE <= 3'h0;
                    // closing onto a fault, or a fault inside the safety time
                    if (fault_any && (!safety_done || CB_CLOSED)) begin
                        inhibited <= 1'b1;
                        set_inhib <= 1'b1;
                    end else if (!inhibit_cond && CB_CONTROL_ON && CB_CLOSED && safety_done) begin
                        inhibited <= 1'b0;
                        state <= S_READY;
                    end
                end
                S_READY: begin
                    if (!CB_CONTROL_ON || !safety_done) begin
                        state <= S_IDLE;
                    end else if (start_c1) begin
                        TRIP_ORDER <= 1'b1;
                        CYCLE <= 3'h1;
                        timer <= 15'h0000;
                        state <= S_DEAD;
                    end else if (OTHER_PROT_TRIP || EXTERNAL_TRIP
                            || fault_any || opened_now) begin
                        inhibited <= 1'b1;
                        set_inhib <= 1'b1;
                        set_final <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_DEAD: begin
                    // breaker stays open, no close before expiry
                    if (timer >= dead_t[dead_idx]) begin
                        timer <= 15'h0000;
                        if (CB_CHARGED) begin
                            CLOSE_ORDER <= 1'b1;
                            state <= S_RECLAIM;
                        end else begin
                            state <= S_EXTEND;
                        end
                    end
                end
                S_EXTEND: begin
                    // waiting for the spring; timer now counts the extension
                    if (CB_CHARGED) begin
                        timer <= 15'h0000;
                        CLOSE_ORDER <= 1'b1;
                        state <= S_RECLAIM;
                    end else if (timer >= waitmax_t) begin
                        inhibited <= 1'b1;
                        set_inhib <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_RECLAIM: begin
                    if (start_cn && CYCLE < cycles_cfg) begin
                        TRIP_ORDER <= 1'b1;
                        CYCLE <= CYCLE + 3'h1;
                        timer <= 15'h0000;
                        state <= S_DEAD;
                    end else if (fault_any || OTHER_PROT_TRIP || EXTERNAL_TRIP) begin
                        TRIP_ORDER <= 1'b1;
                        set_final <= 1'b1;
                        CLOSE_LOCKED <= lock_on_final;
                        state <= S_FINAL;
                    end else if (timer >= reclaim_t) begin
                        set_cleared <= 1'b1;
                        CYCLE <= 3'h0;
                        state <= S_IDLE;
                    end
                end
                S_FINAL: begin
                    // without lock-out this state lasts a single cycle
                    if (!CLOSE_LOCKED) begin
                        CYCLE <= 3'h0;
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
end

endmodule // breaker_recloser_sequencer

//--- verification/breaker_model.sv
`timescale 1ns/1ps
// ====
// breaker moves three cycles after an order
module breaker_model (
    // orders
    input wire clk,
    input wire trip,
    input wire close,
    input wire ext_open,
    input wire man_close,
    input wire [15:0] recharge,
    // state
    output logic closed,
    output logic charged
);
    logic [1:0] op_d = 2'h0;
    logic [1:0] cl_d = 2'h0;
    int left = 0;
    initial closed = 1'b1;
    initial charged = 1'b1;
    // spring reloads after each close, so a quick reclose may find it empty
    always @(posedge clk) begin
        op_d <= {op_d[0], trip | ext_open};
        cl_d <= {cl_d[0], close | man_close};
        if (op_d[1])
            closed <= 1'b0;
        if (cl_d[1]) begin
            closed <= 1'b1;
            charged <= recharge == 16'h0000;
            left <= recharge;
        end else if (left > 1)
            left <= left - 1;
        else
            charged <= 1'b1;
    end
endmodule // breaker_model

//--- verification/breaker_recloser_sequencer_tb.sv
`timescale 1ns/1ps
`include "recloser_defs.vh"
// ====
// bench
module breaker_recloser_sequencer_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext = 1'b0;
    logic man = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] inst = 8'h00;
    logic [7:0] dly = 8'h00;
    logic eqn = 1'b0;
    logic oth = 1'b0;
    logic [31:0] wdata = 32'h0;
    // control off, inhibit, failure, gear fault, manual open
    logic [4:0] inh = 5'h00;
    logic [15:0] recharge = 16'h0;
    integer seed = 32'h948F0BF9;
    int num_errors = 0;
    int tests_run = 0;
    logic [31:0] q_rd[$];
    logic [31:0] q_msk[$];
    logic [3:0] q_ord[$];
    logic [31:0] m;
    logic [31:0] e;
    logic [31:0] dv;
    wire [31:0] rdata;
    wire trip, close, ready, locked, closed, charged;
    wire [2:0] cycle;
    breaker_recloser_sequencer #(.TICK_CYCLES(10)) uut (
        .CLK_SYS(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .TRIP_INST(inst), .TRIP_DELAYED(dly),
        .LOGIC_EQUATION_TRIP_OUTPUT(eqn), .OTHER_PROT_TRIP(oth), .EXTERNAL_TRIP(ext),
        .CB_CONTROL_ON(!inh[0]), .CB_CLOSED(closed), .CB_CHARGED(charged),
        .MANUAL_CLOSE(man), .MANUAL_OPEN(inh[4]), .INHIBIT_IN(inh[1]),
        .BREAKER_FAILURE(inh[2]), .SWITCHGEAR_FAULT(inh[3]), .TRIP_ORDER(trip),
        .CLOSE_ORDER(close), .RECLOSER_READY(ready), .CLOSE_LOCKED(locked), .CYCLE(cycle));
    breaker_model brk (.clk(clk), .trip(trip), .close(close), .ext_open(ext | oth),
        .man_close(man), .recharge(recharge), .closed(closed), .charged(charged));
    initial begin
        forever #10 clk = ~clk;
    end
    // ====
    // checking
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // an order with no note behind it counts as a mismatch
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) begin
            m = q_msk.pop_front();
            check(rdata & m, q_rd.pop_front() & m);
        end
        if (trip || close) begin
            e = q_ord.size() ? q_ord.pop_front() : 32'hFF;
            check({close, e[2:0] == 3'h7 ? 3'h7 : cycle}, e);
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    // ====
    // bus and sequence tasks
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
        q_rd.push_back(x);
        q_msk.push_back(k);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // 0 trip, 1 close, 2 ready
    task automatic wait_for(input int which, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if (which == 0 ? trip : which == 1 ? close : ready) begin
                @(posedge clk);
                return;
            end
        end
        num_errors++;
        $display("wrong value at %0t ns: wait ran out", $time);
    endtask
    // src is {equation, delayed stages, instantaneous stages}
    task automatic fault(input logic [2:0] c, input logic [16:0] src);
        q_ord.push_back({1'b0, c});
        {eqn, dly, inst} <= src;
        wait_for(0, 50);
        {eqn, dly, inst} <= 17'h00000;
    endtask
    task automatic reclose();
        q_ord.push_back(4'hF);
        wait_for(1, 2000);
        repeat (4) @(posedge clk);
    endtask
    // ====
    // scenarios
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_reg(`REG_CYCLES, `RST_CYCLES, 32'hFFFFFFFF);
        rd_reg(`REG_RECLAIM, `RST_RECLAIM, 32'hFFFFFFFF);
        rd_reg(`REG_DEAD4, `RST_DEAD, 32'hFFFFFFFF);
        rd_reg(8'h3C, 32'h0, 32'hFFFFFFFF);
        wr_reg(`REG_CYCLES, 32'h5);
        rd_reg(`REG_CYCLES, 32'h4, 32'h7);
        wr_reg(`REG_START1, 32'h1);
        wr_reg(`REG_START2, 32'h10100);
        wr_reg(`REG_RECLAIM, 32'hA);
        wr_reg(`REG_SAFETY, 32'hA);
        wr_reg(`REG_WAITMAX, 32'hA);
        for (int i = 0; i < 4; i++) begin
            dv = 32'hA + ($random(seed) & 32'h3);
            wr_reg(`REG_DEAD1 + 8'h04 * i, dv);
            rd_reg(`REG_DEAD1 + 8'h04 * i, dv, 32'h7FFF);
        end
        wr_reg(`REG_CYCLES, 32'h2);
        wr_reg(`REG_CTRL, 32'h1);
        $display("registers done");
        wait_for(2, 400);
        for (int i = 0; i < 5; i++) begin
            inh <= 5'h01 << i;
            repeat (6) @(posedge clk);
            @(negedge clk);
            check(ready, 1'b0);
            @(posedge clk);
            inh <= 5'h00;
            wait_for(2, 600);
        end
        $display("ready done");
        rd_reg(`REG_EVENTS, 32'h0, 32'h0);
        // spring ready after the dead time but well inside the extension limit
        recharge <= 16'h0096;
        fault(3'h1, 17'h00001);
        reclose();
        fault(3'h2, 17'h00100);
        reclose();
        repeat (160) @(posedge clk);
        rd_reg(`REG_EVENTS, 32'h1, 32'h1);
        $display("cleared fault done");
        recharge <= 16'h0000;
        wait_for(2, 600);
        wr_reg(`REG_CYCLES, 32'h1);
        wr_reg(`REG_CTRL, 32'h3);
        fault(3'h1, 17'h00001);
        reclose();
        fault(3'h7, 17'h00001);
        repeat (3) @(negedge clk);
        check(locked, 1'b1);
        rd_reg(`REG_STATUS, 32'h220, 32'h7E0);
        rd_reg(`REG_EVENTS, 32'h2, 32'h2);
        wr_reg(`REG_CTRL, 32'h7);
        repeat (2) @(negedge clk);
        check(locked, 1'b0);
        @(posedge clk);
        $display("lockout done");
        man <= 1'b1;
        @(posedge clk);
        man <= 1'b0;
        wait_for(2, 600);
        wr_reg(`REG_CYCLES, 32'h2);
        recharge <= 16'h0190;
        rd_reg(`REG_EVENTS, 32'h0, 32'h0);
        fault(3'h1, 17'h00001);
        reclose();
        fault(3'h2, 17'h10000);
        repeat (400) @(posedge clk);
        rd_reg(`REG_EVENTS, 32'h4, 32'h4);
        $display("recharge limit done");
        recharge <= 16'h0000;
        man <= 1'b1;
        @(posedge clk);
        man <= 1'b0;
        repeat (6) @(posedge clk);
        // a fault inside the safety time must bring no order at all
        inst <= 8'h01;
        repeat (10) @(posedge clk);
        inst <= 8'h00;
        rd_reg(`REG_EVENTS, 32'h4, 32'h4);
        wait_for(2, 600);
        $display("safety done");
        rd_reg(`REG_EVENTS, 32'h0, 32'h0);
        {oth, ext} <= ($random(seed) & 32'h1) ? 2'b10 : 2'b01;
        repeat (6) @(posedge clk);
        {oth, ext} <= 2'b00;
        rd_reg(`REG_EVENTS, 32'h6, 32'h6);
        man <= 1'b1;
        @(posedge clk);
        man <= 1'b0;
        wait_for(2, 600);
        wr_reg(`REG_CTRL, 32'h9);
        @(negedge clk);
        check(ready, 1'b0);
        @(posedge clk);
        $display("external trip and reset done");
        check(q_ord.size(), 32'h0);
        end_sim();
    end
endmodule // breaker_recloser_sequencer_tb

//--- verification/recloser_properties.sv
`timescale 1ns/1ps
// ====
// port checks
module recloser_properties #(
    parameter TICK_CYCLES = 10
) (
    input wire CLK_SYS,
    input wire RSTN,
    input wire RD,
    input wire [31:0] RDATA,
    input wire CB_CONTROL_ON,
    input wire CB_CLOSED,
    input wire CB_CHARGED,
    input wire INHIBIT_IN,
    input wire TRIP_ORDER,
    input wire CLOSE_ORDER,
    input wire RECLOSER_READY,
    input wire CLOSE_LOCKED,
    input wire [2:0] CYCLE
);
    // cycles since the last trip; saturates so a long idle cannot wrap
    int unsigned gap;
    always @(posedge CLK_SYS or negedge RSTN)
        if (!RSTN)
            gap <= 0;
        else if (TRIP_ORDER)
            gap <= 0;
        else if (gap < 100000)
            gap <= gap + 1;
    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    sequence s_held(x);
        x [*3];
    endsequence
    a_ready_closed: assert property (s_held(!CB_CLOSED) |-> !RECLOSER_READY)
        else $error("ready with breaker open");
    a_ready_control: assert property (s_held(!CB_CONTROL_ON) |-> !RECLOSER_READY)
        else $error("ready with control off");
    a_ready_inhibit: assert property (s_held(INHIBIT_IN) |-> !RECLOSER_READY)
        else $error("ready while inhibited");
    a_orders_apart: assert property (!(TRIP_ORDER && CLOSE_ORDER))
        else $error("trip and close together");
    a_trip_pulse: assert property (TRIP_ORDER |=> !TRIP_ORDER)
        else $error("trip longer than one cycle");
    a_first_trip: assert property (TRIP_ORDER && $past(CYCLE) == 3'h0 |-> CYCLE == 3'h1)
        else $error("first trip not in cycle one");
    a_dead_held: assert property (CLOSE_ORDER |-> gap >= 9 * TICK_CYCLES && !CB_CLOSED)
        else $error("close before dead time ran");
    a_close_charged: assert property (CLOSE_ORDER |-> $past(CB_CHARGED))
        else $error("close on uncharged breaker");
    a_close_cycle: assert property (CLOSE_ORDER |-> CYCLE != 3'h0)
        else $error("close outside a cycle");
    a_lock_close: assert property (CLOSE_LOCKED |-> !CLOSE_ORDER)
        else $error("close while locked");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h00000000)
        else $error("read data outside its cycle");
endmodule // recloser_properties

bind breaker_recloser_sequencer recloser_properties #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .CLK_SYS, .RSTN, .RD, .RDATA, .CB_CONTROL_ON, .CB_CLOSED, .CB_CHARGED, .INHIBIT_IN,
    .TRIP_ORDER, .CLOSE_ORDER, .RECLOSER_READY, .CLOSE_LOCKED, .CYCLE);
